/* design/gpac_pkg.sv */
// How it works
// - A direction bit of 1 floats the pin as an input, a 0 drives the output latch onto it.
// - Reading the pin-level register returns the pins, writing it loads the output latch.
// - The output latch has its own select and reads back the latched value, not the pins.
// - The register set is eight bits wide and bit 7 of pin, latch and direction reads zero.
// - When the oscillator owns bit 6, bit 6 of pin, latch and direction reads zero.
// - Bit 6 is digital I/O only in the external-clock, external-clock-PLL and internal I/O modes.
// - In the clock-out modes bit 6 drives the cycle clock, a quarter of the clock rate.
// - After reset bits 5 and 3..0 are analog inputs reading zero and bit 4 is a digital input.
// - A pin selected as analog reads zero whatever its level.
// - An analog pin with its direction bit clear is still driven from its latch.
// - The port-config field of the analog config register picks analog or digital per pin.
// - The bit 4 pin level feeds the timer external clock while bit 4 is an input.
// - The bit 4 pin level always feeds the USB receive input, whatever its direction bit.
// - In crystal and high-speed modes bit 6 carries the oscillator feedback, direction ignored.
// - An enabled peripheral that shares a pin takes the pin over from the port.
package gpac_pkg;

  // register selects
  localparam logic [1:0] SEL_PIN = 2'h0;
  localparam logic [1:0] SEL_LAT = 2'h1;
  localparam logic [1:0] SEL_DIR = 2'h2;
  localparam logic [1:0] SEL_ACFG = 2'h3;

  // field positions and widths
  localparam int unsigned PORT_W = 7;
  localparam int unsigned OSC_BIT = 6;
  localparam int unsigned TMR_BIT = 4;
  localparam int unsigned PCFG_LSB = 0;
  localparam int unsigned PCFG_W = 4;
  localparam int unsigned ACFG_W = 6;
  localparam logic [4:0] PCFG_LAST_AN = 5'h0E;

  // reset values
  localparam logic [6:0] LAT_RST = 7'h00;
  localparam logic [6:0] DIR_RST = 7'h7F;
  localparam logic [5:0] ACFG_RST = 6'h00;

  // cycle clock divide ratio
  localparam int unsigned CYC_DIV_DEF = 4;

  // oscillator configuration, fixed by the configuration bits
  typedef enum logic [2:0] {
    OSC_XT = 3'h0,
    OSC_HS = 3'h1,
    OSC_EC = 3'h3,
    OSC_EXT_CLOCK_WITH_IO_MODE = 3'h2,
    OSC_EXT_CLOCK_PLL_MODE = 3'h6,
    OSC_EXT_CLOCK_PLL_WITH_IO_MODE = 3'h7,
    OSC_INTERNAL_OSC_CLOCKOUT_MODE = 3'h5,
    OSC_INTERNAL_OSC_WITH_IO_MODE = 3'h4
  } gpac_osc_t;

  typedef struct packed {
    logic [6:0] lat;
    logic [6:0] dir;
    logic [5:0] acfg;
    logic [7:0] rdata;
    logic [6:0] pout;
    logic [6:0] poe;
    logic tmr;
    logic usb_xcvr_receive_in;
    logic [6:0] ana;
  } gpac_state_t;

  localparam gpac_state_t ST_RST = '{lat: LAT_RST, dir: DIR_RST, acfg: ACFG_RST, default: '0};

  // analog channel ch is analog while pcfg + ch stays at or below the last code
  function automatic logic ch_is_analog(input logic [3:0] pcfg, input logic [2:0] ch);
    return ({1'b0, pcfg} + {2'b00, ch}) <= PCFG_LAST_AN;
  endfunction

  // merge a write, keeping bit 6 while the oscillator owns it
  function automatic logic [6:0] wr_merge(input logic [6:0] old, input logic [6:0] wd,
                                          input logic io6);
    logic [6:0] r;
    r = wd;
    if (!io6) begin
      r[OSC_BIT] = old[OSC_BIT];
    end
    return r;
  endfunction

endpackage

/* design/gpac_clkdiv.sv */
`timescale 1ns/10ps
module gpac_clkdiv import gpac_pkg::*; #(
  parameter int unsigned DIV = CYC_DIV_DEF
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // divided clock
  output logic cyc_clk_o
);

  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV / 2) : 1;
  localparam logic [CW-1:0] HALF_M1 = CW'(DIV / 2 - 1);

  if (DIV < 2 || (DIV % 2) != 0) begin : g_chk
    $error("divide ratio must be even and at least two");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic clk;
  } gpac_div_t;

  gpac_div_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == HALF_M1) begin
      s_d.cnt = '0;
      s_d.clk = ~s_q.clk;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign cyc_clk_o = s_q.clk;

endmodule

/* design/gpac_anamap.sv */
`timescale 1ns/10ps
module gpac_anamap import gpac_pkg::*; (
  // configuration
  input wire logic [3:0] pcfg_i,
  input wire logic io6_i,
  // per-pin views
  output logic [6:0] analog_o,
  output logic [6:0] dig_rd_o
);

  // analog channels 0..3 sit on pins 0..3, channel 4 on pin 5
  always_comb begin
    analog_o = '0;
    analog_o[0] = ch_is_analog(pcfg_i, 3'h0);
    analog_o[1] = ch_is_analog(pcfg_i, 3'h1);
    analog_o[2] = ch_is_analog(pcfg_i, 3'h2);
    analog_o[3] = ch_is_analog(pcfg_i, 3'h3);
    analog_o[5] = ch_is_analog(pcfg_i, 3'h4);
    dig_rd_o = ~analog_o;
    dig_rd_o[OSC_BIT] = io6_i;
  end

endmodule

/* design/gpac_top.sv */
`timescale 1ns/10ps
module gpac_top import gpac_pkg::*; #(
  parameter int unsigned CYC_DIV = CYC_DIV_DEF
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [1:0] reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // oscillator configuration and feedback
  input wire logic [2:0] osc_mode_i,
  input wire logic osc_fb_i,
  // shared peripherals on bits 5..0
  input wire logic [5:0] periph_en_i,
  input wire logic [5:0] periph_dout_i,
  input wire logic [5:0] periph_doe_i,
  // pins
  input wire logic [6:0] pin_in_i,
  output logic [6:0] pin_out_o,
  output logic [6:0] pin_oe_o,
  // alternate inputs and analog selection
  output logic timer_ext_clock_o,
  output logic usb_xcvr_receive_o,
  output logic [6:0] analog_sel_o
);

  if (CYC_DIV != CYC_DIV_DEF) begin : g_chk
    $error("the cycle clock is a quarter of the clock rate");
  end

  gpac_state_t s_q, s_d;
  gpac_osc_t osc;
  logic io6;
  logic clko6;
  logic xtal6;
  logic cyc_clk;
  logic [6:0] ana;
  logic [6:0] dig_rd;
  logic [6:0] io6_mask;

  assign osc = gpac_osc_t'(osc_mode_i);

  // bit 6 ownership by oscillator configuration
  always_comb begin
    io6 = 1'b0;
    clko6 = 1'b0;
    xtal6 = 1'b0;
    unique case (osc)
      OSC_XT, OSC_HS: xtal6 = 1'b1;
      OSC_EC, OSC_EXT_CLOCK_PLL_MODE, OSC_INTERNAL_OSC_CLOCKOUT_MODE: clko6 = 1'b1;
      OSC_EXT_CLOCK_WITH_IO_MODE, OSC_EXT_CLOCK_PLL_WITH_IO_MODE, OSC_INTERNAL_OSC_WITH_IO_MODE: io6 = 1'b1;
    endcase
  end

  always_comb begin
    io6_mask = 7'h3F;
    io6_mask[OSC_BIT] = io6;
  end

  gpac_clkdiv #(
    .DIV(CYC_DIV)
  ) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cyc_clk_o(cyc_clk)
  );

  gpac_anamap u_map (
    .pcfg_i(s_q.acfg[PCFG_LSB +: PCFG_W]),
    .io6_i(io6),
    .analog_o(ana),
    .dig_rd_o(dig_rd)
  );

  always_comb begin
    s_d = s_q;
    // register writes; a pin-level write only reaches the latch
    if (reg_wr_i) begin
      unique case (reg_sel_i)
        SEL_PIN, SEL_LAT: s_d.lat = wr_merge(s_q.lat, reg_wdata_i[6:0], io6);
        SEL_DIR: s_d.dir = wr_merge(s_q.dir, reg_wdata_i[6:0], io6);
        SEL_ACFG: s_d.acfg = reg_wdata_i[ACFG_W-1:0];
      endcase
    end
    // register reads, held until the next read
    if (reg_rd_i) begin
      unique case (reg_sel_i)
        SEL_PIN: s_d.rdata = {1'b0, pin_in_i & dig_rd};
        SEL_LAT: s_d.rdata = {1'b0, s_q.lat & io6_mask};
        SEL_DIR: s_d.rdata = {1'b0, s_q.dir & io6_mask};
        SEL_ACFG: s_d.rdata = {2'b00, s_q.acfg};
      endcase
    end
    // bits 5..0: latch or shared peripheral, analog selection does not block the driver
    s_d.pout[5:0] = (periph_en_i & periph_dout_i) | (~periph_en_i & s_q.lat[5:0]);
    s_d.poe[5:0] = (periph_en_i & periph_doe_i) | (~periph_en_i & ~s_q.dir[5:0]);
    // bit 6 follows the oscillator configuration
    if (xtal6) begin
      s_d.pout[OSC_BIT] = osc_fb_i;
      s_d.poe[OSC_BIT] = 1'b1;
    end else if (clko6) begin
      s_d.pout[OSC_BIT] = cyc_clk;
      s_d.poe[OSC_BIT] = 1'b1;
    end else begin
      s_d.pout[OSC_BIT] = s_q.lat[OSC_BIT];
      s_d.poe[OSC_BIT] = ~s_q.dir[OSC_BIT];
    end
    // alternate inputs on bit 4
    s_d.tmr = s_q.dir[TMR_BIT] & pin_in_i[TMR_BIT];
    s_d.usb_xcvr_receive_in = pin_in_i[TMR_BIT];
    s_d.ana = ana;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= ST_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign pin_out_o = s_q.pout;
  assign pin_oe_o = s_q.poe;
  assign timer_ext_clock_o = s_q.tmr;
  assign usb_xcvr_receive_o = s_q.usb_xcvr_receive_in;
  assign analog_sel_o = s_q.ana;

  // checks

  dir_drive_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && periph_en_i == 6'h00
    |=> pin_oe_o[5:0] == ~$past(s_q.dir[5:0]) && pin_out_o[5:0] == $past(s_q.lat[5:0])
  ) else $error("port pin drive does not follow direction and latch");

  io6_drive_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && io6
    |=> pin_oe_o[6] == ~$past(s_q.dir[6]) && pin_out_o[6] == $past(s_q.lat[6])
  ) else $error("bit 6 does not act as port pin in an I/O mode");

  pin_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_wr_i && reg_sel_i == SEL_PIN
    |=> s_q.lat[5:0] == $past(reg_wdata_i[5:0]) ##1 pin_out_o[5:0] == $past(s_q.lat[5:0], 1)
        || !$past(ce_i) || $past(periph_en_i) != 6'h00
  ) else $error("pin-level write did not reach the latch");

  pin_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_PIN && s_q.acfg[3:0] == 4'hF && io6
    |=> reg_rdata_o == {1'b0, $past(pin_in_i)}
  ) else $error("pin-level read does not return the pins");

  latch_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_LAT && io6
    |=> reg_rdata_o == {1'b0, $past(s_q.lat)}
  ) else $error("latch read does not return the latch");

  bit7_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    reg_rdata_o[7] == 1'b0
  ) else $error("bit 7 read as one");

  osc_bit6_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i != SEL_ACFG && !io6
    |=> reg_rdata_o[6] == 1'b0
  ) else $error("bit 6 read as one while the oscillator owns it");

  clock_out_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && clko6
    |=> pin_oe_o[6] && pin_out_o[6] == $past(cyc_clk)
  ) else $error("clock-out mode does not drive the cycle clock");

  cyc_period_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && $rose(cyc_clk) ##1 ce_i
    |-> cyc_clk ##1 $fell(cyc_clk)
  ) else $error("cycle clock is not a quarter of the clock rate");

  reset_state_a: assert property (
    @(posedge clk_i)
    rst_i |=> s_q.acfg == ACFG_RST && s_q.dir == DIR_RST
  ) else $error("port does not come out of reset analog and input");

  reset_ana_a: assert property (
    @(posedge clk_i)
    rst_i ##1 !rst_i && ce_i |=> analog_sel_o == 7'h2F
  ) else $error("reset analog selection is wrong");

  analog_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_PIN
    |=> (reg_rdata_o[6:0] & $past(ana)) == 7'h00
  ) else $error("analog pin read as one");

  analog_drive_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ana[0] && !s_q.dir[0] && !periph_en_i[0]
    |=> pin_oe_o[0] && pin_out_o[0] == $past(s_q.lat[0])
  ) else $error("analog selection blocked the output driver");

  pcfg_digital_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_q.acfg[3:0] == 4'hF |-> ana == 7'h00
  ) else $error("all-digital port configuration left an analog pin");

  timer_clk_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.dir[TMR_BIT]
    |=> timer_ext_clock_o == $past(pin_in_i[TMR_BIT])
  ) else $error("timer clock does not follow bit 4");

  usb_rcv_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> usb_xcvr_receive_o == $past(pin_in_i[TMR_BIT])
  ) else $error("USB receive input does not follow bit 4");

  osc_feedback_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && xtal6
    |=> pin_oe_o[6] && pin_out_o[6] == $past(osc_fb_i)
  ) else $error("crystal mode does not carry the oscillator feedback");

  periph_take_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && periph_en_i[0]
    |=> pin_out_o[0] == $past(periph_dout_i[0]) && pin_oe_o[0] == $past(periph_doe_i[0])
  ) else $error("enabled peripheral did not take the pin");

  freeze_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(s_q.lat) && $stable(s_q.dir) && $stable(reg_rdata_o)
  ) else $error("state moved while the clock enable was low");

  cyc_low_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && $fell(cyc_clk) && !$past(rst_i) ##1 ce_i
    |-> !cyc_clk ##1 $rose(cyc_clk)
  ) else $error("cycle clock low phase is not two cycles");

  lat_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_wr_i && reg_sel_i == SEL_LAT
    |=> s_q.lat[5:0] == $past(reg_wdata_i[5:0])
  ) else $error("latch write did not land");

  dir_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_wr_i && reg_sel_i == SEL_DIR
    |=> s_q.dir[5:0] == $past(reg_wdata_i[5:0])
  ) else $error("direction write did not land");

  acfg_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_wr_i && reg_sel_i == SEL_ACFG
    |=> s_q.acfg == $past(reg_wdata_i[5:0])
  ) else $error("analog config write did not land");

  osc_lat_keep_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_wr_i && reg_sel_i != SEL_DIR && reg_sel_i != SEL_ACFG && !io6
    |=> s_q.lat[6] == $past(s_q.lat[6])
  ) else $error("latch bit 6 written while the oscillator owns it");

  osc_dir_keep_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_wr_i && reg_sel_i == SEL_DIR && !io6
    |=> s_q.dir[6] == $past(s_q.dir[6])
  ) else $error("direction bit 6 written while the oscillator owns it");

  dir_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_DIR
    |=> reg_rdata_o[5:0] == $past(s_q.dir[5:0])
  ) else $error("direction read does not return the direction bits");

  latch_osc_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_LAT && !io6
    |=> reg_rdata_o[5:0] == $past(s_q.lat[5:0])
  ) else $error("latch read wrong while the oscillator owns bit 6");

  acfg_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_ACFG
    |=> reg_rdata_o == {2'b00, $past(s_q.acfg)}
  ) else $error("analog config read does not return the field");

  pin6_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_PIN && io6
    |=> reg_rdata_o[6] == $past(pin_in_i[6])
  ) else $error("bit 6 pin read wrong in an I/O mode");

  digital_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && reg_rd_i && reg_sel_i == SEL_PIN
    |=> reg_rdata_o[5:0] == ($past(pin_in_i[5:0]) & ~$past(ana[5:0]))
  ) else $error("digital pin read does not return the pin level");

  rdata_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ce_i || !reg_rd_i |=> $stable(reg_rdata_o)
  ) else $error("read data moved without a read");

  analog_sel_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> analog_sel_o == $past(ana)
  ) else $error("analog selection output does not follow the config");

  timer_gate_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !s_q.dir[TMR_BIT] |=> !timer_ext_clock_o
  ) else $error("timer clock not held low while bit 4 drives");

  periph_oe_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> ((pin_oe_o[5:0] ^ $past(periph_doe_i)) & $past(periph_en_i)) == 6'h00
  ) else $error("enabled peripheral does not own the pin enable");

  periph_out_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> ((pin_out_o[5:0] ^ $past(periph_dout_i)) & $past(periph_en_i)) == 6'h00
  ) else $error("enabled peripheral does not own the pin value");

  reset_out_a: assert property (
    @(posedge clk_i)
    rst_i |=> pin_oe_o == 7'h00 && reg_rdata_o == 8'h00 && s_q.lat == LAT_RST
  ) else $error("pins or read data not quiet after reset");

  osc_own_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !io6 |=> pin_oe_o[6]
  ) else $error("oscillator-owned bit 6 is not driven");

  freeze_pins_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(pin_out_o) && $stable(pin_oe_o) && $stable(s_q.acfg)
  ) else $error("pins moved while the clock enable was low");

endmodule

/* testbench/gpac_board.sv */
`timescale 1ns/10ps
module gpac_board (
  // device side
  input wire logic [6:0] pin_out_i,
  input wire logic [6:0] pin_oe_i,
  // board side
  input wire logic [6:0] drive_i,
  output logic [6:0] pin_in_o
);
  // a pin follows the device only where its driver is on, else the board
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & drive_i);
endmodule

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
  import gpac_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [1:0] reg_sel_i = 2'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [2:0] osc_mode_i = OSC_EXT_CLOCK_WITH_IO_MODE;
  logic osc_fb_i = 1'b0;
  logic [5:0] periph_en_i = 6'h00;
  logic [5:0] periph_dout_i = 6'h00;
  logic [5:0] periph_doe_i = 6'h00;
  logic [6:0] pin_in_i;
  logic [6:0] pin_out_o;
  logic [6:0] pin_oe_o;
  logic timer_ext_clock_o;
  logic usb_xcvr_receive_o;
  logic [6:0] analog_sel_o;
  logic [6:0] board_drv = 7'h7F;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [2:0] modes [8] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h5, 3'h2, 3'h7, 3'h4};
  logic [7:0] s;
  logic io;

  always #2.5 clk_i = ~clk_i;

  gpac_top #(.CYC_DIV(4)) u_gpac_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .osc_mode_i(osc_mode_i),
    .osc_fb_i(osc_fb_i), .periph_en_i(periph_en_i), .periph_dout_i(periph_dout_i),
    .periph_doe_i(periph_doe_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .timer_ext_clock_o(timer_ext_clock_o),
    .usb_xcvr_receive_o(usb_xcvr_receive_o), .analog_sel_o(analog_sel_o));

  gpac_board u_gpac_board (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
    .drive_i(board_drv), .pin_in_o(pin_in_i));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk_i);
    reg_sel_i <= sel;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [1:0] sel, input logic [7:0] e);
    @(posedge clk_i);
    reg_sel_i <= sel;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, reg_rdata_o, e);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge clk_i);
    osc_mode_i <= m;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // pins 0..3 carry channels 0..3, pin 5 carries channel 4
  function automatic logic [6:0] exp_ana(input int p);
    logic [6:0] r;
    r = 7'h00;
    for (int n = 0; n < 5; n++) begin
      if (p + n <= 14) begin
        r[(n < 4) ? n : 5] = 1'b1;
      end
    end
    return r;
  endfunction

  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    do_reset(OSC_EXT_CLOCK_WITH_IO_MODE);
    #1;
    chk("ana_rst", {1'b0, analog_sel_o}, 8'h2F);
    chk("oe_rst", {1'b0, pin_oe_o}, 8'h00);
    rd("lat_rst", SEL_LAT, 8'h00);
    rd("dir_rst", SEL_DIR, 8'h7F);
    rd("acfg_rst", SEL_ACFG, 8'h00);
    rd("pin_rst", SEL_PIN, 8'h50);
    for (int p = 0; p < 16; p++) begin
      wr(SEL_ACFG, 8'hC0 | 8'(p));
      rd("acfg", SEL_ACFG, 8'h00 | 8'(p));
      chk("ana", {1'b0, analog_sel_o}, {1'b0, exp_ana(p)});
      rd("pin_ana", SEL_PIN, {1'b0, ~exp_ana(p)});
    end
    wr(SEL_PIN, 8'h55);
    rd("lat", SEL_LAT, 8'h55);
    rd("pin_in", SEL_PIN, 8'h7F);
    wr(SEL_DIR, 8'h00);
    settle();
    chk("oe_out", {1'b0, pin_oe_o}, 8'h7F);
    chk("out", {1'b0, pin_out_o}, 8'h55);
    rd("pin_drv", SEL_PIN, 8'h55);
    wr(SEL_ACFG, 8'h00);
    settle();
    chk("oe_ana", {1'b0, pin_oe_o}, 8'h7F);
    chk("out_ana", {1'b0, pin_out_o}, 8'h55);
    chk("tmr_out", {7'h0, timer_ext_clock_o}, 8'h00);
    chk("usb_out", {7'h0, usb_xcvr_receive_o}, 8'h01);
    wr(SEL_DIR, 8'h7F);
    settle();
    chk("tmr_in", {7'h0, timer_ext_clock_o}, 8'h01);
    @(posedge clk_i);
    board_drv <= 7'h00;
    settle();
    chk("tmr_lo", {7'h0, timer_ext_clock_o}, 8'h00);
    chk("usb_lo", {7'h0, usb_xcvr_receive_o}, 8'h00);
    @(posedge clk_i);
    periph_en_i <= 6'h01;
    periph_dout_i <= 6'h01;
    periph_doe_i <= 6'h01;
    settle();
    chk("periph", {6'h0, pin_oe_o[0], pin_out_o[0]}, 8'h03);
    @(posedge clk_i);
    periph_en_i <= 6'h00;
    ce_i <= 1'b0;
    wr(SEL_LAT, 8'h00);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd("lat_ce", SEL_LAT, 8'h55);
    wr(SEL_LAT, 8'hFF);
    rd("lat_b7", SEL_LAT, 8'h7F);
    @(posedge clk_i);
    board_drv <= 7'h55;
    for (int k = 0; k < 8; k++) begin
      do_reset(modes[k]);
      io = (modes[k] == OSC_EXT_CLOCK_WITH_IO_MODE) || (modes[k] == OSC_EXT_CLOCK_PLL_WITH_IO_MODE) || (modes[k] == OSC_INTERNAL_OSC_WITH_IO_MODE);
      wr(SEL_LAT, 8'hFF);
      wr(SEL_DIR, 8'h40);
      rd("lat6", SEL_LAT, io ? 8'h7F : 8'h3F);
      rd("dir6", SEL_DIR, io ? 8'h40 : 8'h00);
      rd("pin6", SEL_PIN, io ? 8'h50 : 8'h10);
      chk("oe6", {7'h0, pin_oe_o[6]}, {7'h0, !io});
      if (modes[k] == OSC_XT || modes[k] == OSC_HS) begin
        @(posedge clk_i);
        osc_fb_i <= 1'b1;
        settle();
        chk("fb_hi", {7'h0, pin_out_o[6]}, 8'h01);
        @(posedge clk_i);
        osc_fb_i <= 1'b0;
        settle();
        chk("fb_lo", {7'h0, pin_out_o[6]}, 8'h00);
      end else if (!io) begin
        for (int i = 0; i < 8; i++) begin
          @(posedge clk_i);
          #1;
          s[i] = pin_out_o[6];
        end
        chk("cyc_clk", {2'h0, s[5:0] ^ s[7:2]}, 8'h3F);
      end
    end
    end_of_test();
  end
endmodule
